// File: common/rcp_regs.svh
// Register offsets, reset values, field positions and timing figures
`ifndef RCP_REGS_SVH
`define RCP_REGS_SVH

`define RCP_OFS_GREEN_G3 8'h0a
`define RCP_OFS_BLUE_G3 8'h0b
`define RCP_OFS_RED_G4 8'h0c
`define RCP_OFS_GREEN_G4 8'h0d
`define RCP_OFS_BLUE_G4 8'h0e
`define RCP_OFS_PATTERN_CTL 8'h0f
`define RCP_OFS_FADE_SEL 8'h10
`define RCP_OFS_G1_ONOFF 8'h11
`define RCP_NUM_REGS 8

`define RCP_RST_ZERO 8'h00
`define RCP_RST_BLUE_BREATHE 8'h40
`define RCP_RST_CTL_BREATHE 8'hdf
`define RCP_RST_SLOTBITS_BREATHE 8'h07

`define RCP_MODE_MSB 7
`define RCP_MODE_LSB 6
`define RCP_DUR_MSB 5
`define RCP_DUR_LSB 3
`define RCP_FADE2_MSB 2
`define RCP_FADE2_LSB 0

`define RCP_CODE_FULL_SCALE 8'hc0
`define RCP_STEP_UA 125

`define RCP_CLK_NS 5
`define RCP_MS_NS 1000000

`define RCP_SLOT_MS_0 188
`define RCP_SLOT_MS_1 250
`define RCP_SLOT_MS_2 375
`define RCP_SLOT_MS_3 500
`define RCP_SLOT_MS_4 750
`define RCP_SLOT_MS_5 1000
`define RCP_SLOT_MS_6 1500
`define RCP_SLOT_MS_7 2000

`define RCP_FADE_MS_0 32
`define RCP_FADE_MS_1 63
`define RCP_FADE_MS_2 125
`define RCP_FADE_MS_3 250
`define RCP_FADE_MS_4 500
`define RCP_FADE_MS_5 1000
`define RCP_FADE_MS_6 2000
`define RCP_FADE_MS_7 4000

`endif

// File: common/rcp_pkg.sv
// Types for the LED current and pattern configuration block
package rcp_pkg;
   typedef enum logic [3:0] {
      RCP_IDLE, RCP_ADDR, RCP_ADDR_ACK, RCP_REG, RCP_REG_ACK,
      RCP_WDATA, RCP_WDATA_ACK, RCP_RDATA, RCP_RDATA_ACK
   } rcp_state_e;
   typedef logic [7:0] rcp_byte_t;
   typedef logic [2:0] rcp_idx_t;
endpackage : rcp_pkg

// File: rtl/rcp_top.sv
// I2C register bank for LED current codes and the pattern engine
`timescale 1ns/1ps
`include "rcp_regs.svh"

// Operation
// - Current code maps linearly, 125 uA per step, 24 mA at 0xc0.
// - Codes above 0xc0 act as full scale.
// - Blue codes reset to 0, or 0x40 (8 mA) in breathe variant.
// - Red and green codes reset to zero and are read/write.
// - Mode field 7:6: off, or engine with 4, 6, 8 slots.
// - Mode resets to 00, or 11 in breathe variant.
// - Slot duration field 5:3 selects 188 ms up to 2.0 s.
// - Slot duration resets to 000, or 011 (500 ms) in breathe variant.
// - Second fade field 2:0 selects 32 ms up to 4 s.
// - Second fade resets to 000, or 111 in breathe variant.
// - Per-slot bit picks first (0) or second (1) fade constant.
// - Fade select bits 7:3 reset 0; bits 2:0 reset 1 in breathe variant.
// - Group 1 per-slot bit: 0 fades down off, 1 turns on fading up.
// - On/off bits 7:3 reset 0; bits 2:0 reset 1 in breathe variant.
// - Enable mode: 00 off, 01 night, 10 normal, 11 restore defaults.
// - First fade constant uses the same 32 ms to 4 s encoding.
module rcp_top
   import rcp_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h74,
   parameter bit BREATHE_VARIANT = 1'b0,
   parameter int unsigned MS_CYCLES = `RCP_MS_NS / `RCP_CLK_NS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // I2C pins, open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // From the control register
   input wire logic [1:0] enable_mode,
   input wire logic [2:0] first_fade_constant,
   // Clamped current codes
   output logic [7:0] green_code_group3,
   output logic [7:0] blue_code_group3,
   output logic [7:0] red_code_group4,
   output logic [7:0] green_code_group4,
   output logic [7:0] blue_code_group4,
   // Operating state
   output logic night_range,
   output logic shutdown,
   output logic engine_on,
   output logic [2:0] active_slot,
   output logic [11:0] active_fade_ms,
   output logic group1_on
);

   ////////////////////////////////////////////////////////////////////////
   function automatic rcp_byte_t reset_value(input rcp_idx_t idx);
      rcp_byte_t v;
      v = `RCP_RST_ZERO;
      if (BREATHE_VARIANT) begin
         unique case (idx)
            3'd1, 3'd4: v = `RCP_RST_BLUE_BREATHE;
            3'd5: v = `RCP_RST_CTL_BREATHE;
            3'd6, 3'd7: v = `RCP_RST_SLOTBITS_BREATHE;
            default: v = `RCP_RST_ZERO;
         endcase
      end
      return v;
   endfunction : reset_value

   function automatic logic in_map(input rcp_byte_t ptr);
      return (ptr >= `RCP_OFS_GREEN_G3) && (ptr <= `RCP_OFS_G1_ONOFF);
   endfunction : in_map

   function automatic rcp_idx_t reg_idx(input rcp_byte_t ptr);
      rcp_byte_t d;
      d = ptr - `RCP_OFS_GREEN_G3;
      return d[2:0];
   endfunction : reg_idx

   function automatic rcp_byte_t clamp(input rcp_byte_t code);
      return (code > `RCP_CODE_FULL_SCALE) ? `RCP_CODE_FULL_SCALE : code;
   endfunction : clamp

   function automatic logic [10:0] slot_ms(input logic [2:0] c);
      logic [10:0] v;
      v = 11'(`RCP_SLOT_MS_0);
      unique case (c)
         3'd0: v = 11'(`RCP_SLOT_MS_0);
         3'd1: v = 11'(`RCP_SLOT_MS_1);
         3'd2: v = 11'(`RCP_SLOT_MS_2);
         3'd3: v = 11'(`RCP_SLOT_MS_3);
         3'd4: v = 11'(`RCP_SLOT_MS_4);
         3'd5: v = 11'(`RCP_SLOT_MS_5);
         3'd6: v = 11'(`RCP_SLOT_MS_6);
         3'd7: v = 11'(`RCP_SLOT_MS_7);
      endcase
      return v;
   endfunction : slot_ms

   function automatic logic [11:0] fade_ms(input logic [2:0] c);
      logic [11:0] v;
      v = 12'(`RCP_FADE_MS_0);
      unique case (c)
         3'd0: v = 12'(`RCP_FADE_MS_0);
         3'd1: v = 12'(`RCP_FADE_MS_1);
         3'd2: v = 12'(`RCP_FADE_MS_2);
         3'd3: v = 12'(`RCP_FADE_MS_3);
         3'd4: v = 12'(`RCP_FADE_MS_4);
         3'd5: v = 12'(`RCP_FADE_MS_5);
         3'd6: v = 12'(`RCP_FADE_MS_6);
         3'd7: v = 12'(`RCP_FADE_MS_7);
      endcase
      return v;
   endfunction : fade_ms

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; third stage only for edge detection
   logic [2:0] scl_q, sda_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else begin
         scl_q <= {scl_q[1:0], scl_i};
         sda_q <= {sda_q[1:0], sda_i};
      end
   end
   logic scl_rise, scl_fall, bus_start, bus_stop, sda_s;
   assign sda_s = sda_q[1];
   assign scl_rise = scl_q[1] && !scl_q[2];
   assign scl_fall = !scl_q[1] && scl_q[2];
   assign bus_start = scl_q[1] && scl_q[2] && !sda_q[1] && sda_q[2];
   assign bus_stop = scl_q[1] && scl_q[2] && sda_q[1] && !sda_q[2];

   ////////////////////////////////////////////////////////////////////////
   rcp_state_e state_q;
   rcp_byte_t shift_q, ptr_q, tx_q;
   logic [3:0] bits_q;
   logic rw_q, mack_q, wr_q;
   rcp_byte_t wr_data_q, wr_ptr_q;
   rcp_byte_t regs_q [`RCP_NUM_REGS];
   rcp_byte_t rd_byte;
   assign rd_byte = in_map(ptr_q) ? regs_q[reg_idx(ptr_q)] : `RCP_RST_ZERO;

   // address byte, then data bytes with auto-increment
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= RCP_IDLE;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         tx_q <= 8'h00;
         bits_q <= 4'h0;
         rw_q <= 1'b0;
         mack_q <= 1'b1;
         wr_q <= 1'b0;
         wr_data_q <= 8'h00;
         wr_ptr_q <= 8'h00;
         sda_oe <= 1'b0;
      end else begin
         wr_q <= 1'b0;
         if (bus_start) begin
            state_q <= RCP_ADDR;
            bits_q <= 4'h0;
            sda_oe <= 1'b0;
         end else if (bus_stop) begin
            state_q <= RCP_IDLE;
            sda_oe <= 1'b0;
         end else if (scl_rise) begin
            if (state_q == RCP_RDATA_ACK) begin
               mack_q <= sda_s;
            end else if (state_q inside {RCP_ADDR, RCP_REG, RCP_WDATA}) begin
               shift_q <= {shift_q[6:0], sda_s};
               bits_q <= bits_q + 4'h1;
            end
         end else if (scl_fall) begin
            unique case (state_q)
               RCP_IDLE: ;
               RCP_ADDR, RCP_REG, RCP_WDATA: begin
                  if (bits_q == 4'h8) begin
                     bits_q <= 4'h0;
                     sda_oe <= 1'b1;
                     if (state_q == RCP_ADDR) begin
                        rw_q <= shift_q[0];
                        state_q <= RCP_ADDR_ACK;
                        if (shift_q[7:1] != DEV_ADDR) begin
                           sda_oe <= 1'b0;
                           state_q <= RCP_IDLE;
                        end
                     end else if (state_q == RCP_REG) begin
                        ptr_q <= shift_q;
                        state_q <= RCP_REG_ACK;
                     end else begin
                        wr_q <= 1'b1;
                        wr_data_q <= shift_q;
                        wr_ptr_q <= ptr_q;
                        ptr_q <= ptr_q + 8'h01;
                        state_q <= RCP_WDATA_ACK;
                     end
                  end
               end
               RCP_ADDR_ACK, RCP_RDATA_ACK: begin
                  if (state_q == RCP_RDATA_ACK && mack_q) begin
                     sda_oe <= 1'b0;
                     state_q <= RCP_IDLE;
                  end else if (rw_q) begin
                     // First data bit goes out on the ack's falling edge
                     sda_oe <= !rd_byte[7];
                     tx_q <= {rd_byte[6:0], 1'b0};
                     ptr_q <= ptr_q + 8'h01;
                     bits_q <= 4'h1;
                     state_q <= RCP_RDATA;
                  end else begin
                     sda_oe <= 1'b0;
                     state_q <= RCP_REG;
                  end
               end
               RCP_REG_ACK, RCP_WDATA_ACK: begin
                  sda_oe <= 1'b0;
                  state_q <= RCP_WDATA;
               end
               RCP_RDATA: begin
                  if (bits_q == 4'h8) begin
                     sda_oe <= 1'b0;
                     state_q <= RCP_RDATA_ACK;
                  end else begin
                     sda_oe <= !tx_q[7];
                     tx_q <= {tx_q[6:0], 1'b0};
                     bits_q <= bits_q + 4'h1;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // variant reset and restore
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `RCP_NUM_REGS; i++) begin
            regs_q[i] <= reset_value(3'(i));
         end
      end else if (enable_mode == 2'b11) begin
         // restore wins over a write in the same cycle
         for (int i = 0; i < `RCP_NUM_REGS; i++) begin
            regs_q[i] <= reset_value(3'(i));
         end
      end else if (wr_q && in_map(wr_ptr_q)) begin
         regs_q[reg_idx(wr_ptr_q)] <= wr_data_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // current codes, clamped, zero target when off
   generate
      for (genvar g = 0; g < 5; g++) begin : g_code
         logic [7:0] code_q;
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               code_q <= 8'h00;
            end else begin
               code_q <= (enable_mode == 2'b00) ? 8'h00 : clamp(regs_q[g]);
            end
         end
      end
   endgenerate
   assign green_code_group3 = g_code[0].code_q;
   assign blue_code_group3 = g_code[1].code_q;
   assign red_code_group4 = g_code[2].code_q;
   assign green_code_group4 = g_code[3].code_q;
   assign blue_code_group4 = g_code[4].code_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         night_range <= 1'b0;
         shutdown <= 1'b1;
      end else begin
         night_range <= (enable_mode == 2'b01);
         shutdown <= (enable_mode == 2'b00);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [1:0] pmode;
   logic [2:0] dur, last_slot;
   logic [31:0] ms_cnt_q;
   logic [10:0] slot_ms_q;
   logic [2:0] slot_q;
   logic ms_tick, slot_end, run;
   assign pmode = regs_q[5][`RCP_MODE_MSB:`RCP_MODE_LSB];
   assign dur = regs_q[5][`RCP_DUR_MSB:`RCP_DUR_LSB];
   // last slot for 4, 6 or 8 slots
   assign last_slot = (pmode == 2'b01) ? 3'd3 : (pmode == 2'b10) ? 3'd5 : 3'd7;
   // Engine stops while the device is off
   assign run = (pmode != 2'b00) && (enable_mode != 2'b00);
   assign ms_tick = (ms_cnt_q == MS_CYCLES - 1);
   // slot held for its duration in milliseconds
   // Shorter duration written mid-slot ends the slot at the next millisecond tick
   assign slot_end = ms_tick && (slot_ms_q >= slot_ms(dur) - 11'd1);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ms_cnt_q <= 32'h0;
         slot_ms_q <= 11'h0;
         slot_q <= 3'h0;
      end else if (!run) begin
         ms_cnt_q <= 32'h0;
         slot_ms_q <= 11'h0;
         slot_q <= 3'h0;
      end else begin
         ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
         if (slot_end) begin
            slot_ms_q <= 11'h0;
            // wrap after the last enabled slot
            slot_q <= (slot_q >= last_slot) ? 3'h0 : slot_q + 3'h1;
         end else if (ms_tick) begin
            slot_ms_q <= slot_ms_q + 11'h1;
         end
      end
   end

   // per-slot fade and group 1 state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         engine_on <= 1'b0;
         active_slot <= 3'h0;
         active_fade_ms <= 12'h0;
         group1_on <= 1'b0;
      end else begin
         engine_on <= run;
         active_slot <= slot_q;
         group1_on <= run && regs_q[7][slot_q];
         active_fade_ms <= (run && regs_q[6][slot_q]) ?
            fade_ms(regs_q[5][`RCP_FADE2_MSB:`RCP_FADE2_LSB]) :
            fade_ms(first_fade_constant);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_slot_done;
      run && slot_end;
   endsequence
   sequence s_wrap_point;
      s_slot_done ##0 (slot_q >= last_slot);
   endsequence

   AST_LINEAR: assert property (@(posedge clk) disable iff (!arst_n)
      (enable_mode != 2'b00 && regs_q[3] <= 8'hc0) |=> green_code_group4 == $past(regs_q[3]))
      else $error("Current code not passed through");
   AST_CLAMP: assert property (@(posedge clk) disable iff (!arst_n)
      (enable_mode != 2'b00 && regs_q[1] > 8'hc0) |=> blue_code_group3 == 8'hc0)
      else $error("Current code not clamped");
   AST_RST_BLUE: assert property (@(posedge clk) disable iff (!arst_n)
      enable_mode == 2'b11 |=> regs_q[4] == (BREATHE_VARIANT ? 8'h40 : 8'h00))
      else $error("Blue code restore wrong");
   AST_RST_RG: assert property (@(posedge clk) disable iff (!arst_n)
      enable_mode == 2'b11 |=> regs_q[0] == 8'h00 && regs_q[2] == 8'h00)
      else $error("Red or green code restore wrong");
   AST_MODE_OFF: assert property (@(posedge clk) disable iff (!arst_n)
      pmode == 2'b00 |=> !engine_on && slot_q == 3'h0)
      else $error("Engine runs with mode off");
   AST_RST_CTL: assert property (@(posedge clk) disable iff (!arst_n)
      enable_mode == 2'b11 |=> regs_q[5] == (BREATHE_VARIANT ? 8'hdf : 8'h00))
      else $error("Pattern control restore wrong");
   AST_SLOT_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
      (run && $changed(slot_q) && $past(run)) |-> $past(slot_end))
      else $error("Slot changed before its duration");
   AST_RST_SLOTBITS: assert property (@(posedge clk) disable iff (!arst_n)
      enable_mode == 2'b11 |=> regs_q[6] == regs_q[7] && regs_q[7][7:3] == 5'h00)
      else $error("Slot bit restore wrong");
   AST_FADE_SEL: assert property (@(posedge clk) disable iff (!arst_n)
      (run && regs_q[6][slot_q]) |=>
      active_fade_ms == fade_ms($past(regs_q[5][2:0])))
      else $error("Second fade constant not selected");
   AST_ONOFF: assert property (@(posedge clk) disable iff (!arst_n)
      run |=> group1_on == $past(regs_q[7][slot_q]))
      else $error("Group 1 on/off does not follow slot");
   AST_WRAP: assert property (@(posedge clk) disable iff (!arst_n)
      s_wrap_point |=> slot_q == 3'h0)
      else $error("Slot did not wrap to zero");

endmodule : rcp_top

// File: dv/rcp_i2c_host.sv
// I2C host model that reaches the configuration registers
`timescale 1ns/1ps
module rcp_i2c_host (
   // Clock of the bench
   input wire logic clk,
   // Resolved data wire, pulled up
   input wire logic sda,
   // Host pins
   output logic scl,
   output logic sda_oe
);
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic hclk(input int n);
      repeat (n) @(negedge clk);
   endtask : hclk
   // bit phases
   // Data moves only while SCL is low, so no false START or STOP
   task automatic bit_out(input logic b);
      scl = 1'b0;
      hclk(4);
      sda_oe = ~b;
      hclk(4);
      scl = 1'b1;
      hclk(8);
   endtask : bit_out
   task automatic bit_in(output logic b);
      scl = 1'b0;
      hclk(4);
      sda_oe = 1'b0;
      hclk(4);
      scl = 1'b1;
      hclk(4);
      b = sda;
      hclk(4);
   endtask : bit_in
   task automatic start();
      // Repeated start: SDA may still be held low by an ack
      if (!scl || !sda) begin
         bit_out(1'b1);
      end
      sda_oe = 1'b1;
      hclk(8);
   endtask : start
   task automatic stop();
      bit_out(1'b0);
      sda_oe = 1'b0;
      hclk(8);
   endtask : stop
   task automatic byte_out(input logic [7:0] d, inout logic ok);
      logic nack;
      for (int i = 7; i >= 0; i--) begin
         bit_out(d[i]);
      end
      bit_in(nack);
      ok = ok & ~nack;
   endtask : byte_out
   task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d[$],
                     output logic ok);
      ok = 1'b1;
      start();
      byte_out({a, 1'b0}, ok);
      byte_out(r, ok);
      foreach (d[i]) begin
         byte_out(d[i], ok);
      end
      stop();
   endtask : wr
   // pointer set, repeated start, read with NACK on the last byte
   task automatic rd(input logic [6:0] a, input logic [7:0] r, input int n,
                     output logic [7:0] q[$], output logic ok);
      logic [7:0] b;
      ok = 1'b1;
      q = {};
      start();
      byte_out({a, 1'b0}, ok);
      byte_out(r, ok);
      start();
      byte_out({a, 1'b1}, ok);
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) begin
            bit_in(b[i]);
         end
         bit_out(k == n - 1);
         q.push_back(b);
      end
      stop();
   endtask : rd
endmodule : rcp_i2c_host

// File: dv/rcp_top_tb.sv
// Self-checking bench for the LED current and pattern register bank
`timescale 1ns/1ps
module rcp_top_tb;
   import rcp_pkg::*;
   localparam int MS = 4;
   // Arbitrary address for the breathe-variant instance
   localparam logic [6:0] ADDR_B = 7'h33;
   localparam int SLOT_MS[8] = '{188, 250, 375, 500, 750, 1000, 1500, 2000};
   localparam int FADE_MS[8] = '{32, 63, 125, 250, 500, 1000, 2000, 4000};
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [1:0] enable_mode = 2'h2;
   logic [2:0] first_fade_constant = 3'h0;
   logic scl;
   logic host_oe;
   logic sda;
   logic oe_a;
   logic oe_b;
   logic [7:0] code [5];
   logic night_range, shutdown, engine_on, group1_on, eng_b;
   logic [2:0] active_slot;
   logic [11:0] active_fade_ms;
   logic [7:0] blue_b;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;
   logic ok;
   logic [7:0] q[$];
   // Pull-up on the shared data wire
   assign sda = ~(oe_a | oe_b | host_oe);
   initial begin
      forever #2.5 clk = ~clk;
   end
   rcp_top #(.BREATHE_VARIANT(1'b0), .MS_CYCLES(MS)) i_rcp_top (
      .clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(oe_a),
      .enable_mode(enable_mode), .first_fade_constant(first_fade_constant),
      .green_code_group3(code[0]), .blue_code_group3(code[1]), .red_code_group4(code[2]),
      .green_code_group4(code[3]), .blue_code_group4(code[4]), .night_range(night_range),
      .shutdown(shutdown), .engine_on(engine_on), .active_slot(active_slot),
      .active_fade_ms(active_fade_ms), .group1_on(group1_on));
   rcp_top #(.DEV_ADDR(ADDR_B), .BREATHE_VARIANT(1'b1), .MS_CYCLES(MS)) i_rcp_top_breathe (
      .clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(oe_b),
      .enable_mode(enable_mode), .first_fade_constant(first_fade_constant),
      .green_code_group3(), .blue_code_group3(blue_b), .red_code_group4(),
      .green_code_group4(), .blue_code_group4(), .night_range(), .shutdown(),
      .engine_on(eng_b), .active_slot(), .active_fade_ms(), .group1_on());
   rcp_i2c_host i_rcp_i2c_host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic results();
      if (n_fail == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   always @(posedge clk) begin
      cycles <= cycles + 1;
      // Longest run of all scenarios is well under this
      if (cycles == 90000) begin
         n_fail++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults();
      logic [7:0] exp_b[8] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h40, 8'hdf, 8'h07, 8'h07};
      i_rcp_i2c_host.rd(7'h74, 8'h0a, 8, q, ok);
      chk(ok, 1'b1, "read ack");
      for (int i = 0; i < 8; i++) chk(q[i], 8'h00, "plain default");
      i_rcp_i2c_host.rd(ADDR_B, 8'h0a, 8, q, ok);
      for (int i = 0; i < 8; i++) chk(q[i], exp_b[i], "breathe default");
      chk(blue_b, 8'h40, "breathe blue code");
      chk(eng_b, 1'b1, "breathe engine");
      chk(engine_on, 1'b0, "plain engine");
   endtask : t_defaults
   task automatic t_codes();
      logic [7:0] wv[5] = '{8'hc0, 8'hc1, 8'hff, 8'h01, 8'hbf};
      i_rcp_i2c_host.wr(7'h74, 8'h0a, '{8'hc0, 8'hc1, 8'hff, 8'h01, 8'hbf}, ok);
      for (int i = 0; i < 5; i++) chk(code[i], (wv[i] > 8'hc0) ? 8'hc0 : wv[i], "code");
      i_rcp_i2c_host.rd(7'h74, 8'h0a, 5, q, ok);
      for (int i = 0; i < 5; i++) chk(q[i], wv[i], "raw readback");
      i_rcp_i2c_host.wr(7'h74, 8'h05, '{8'h5a}, ok);
      chk(ok, 1'b1, "unmapped write ack");
      i_rcp_i2c_host.rd(7'h74, 8'h05, 1, q, ok);
      chk(q[0], 8'h00, "unmapped read");
      i_rcp_i2c_host.wr(7'h11, 8'h0a, '{8'h12}, ok);
      chk(ok, 1'b0, "foreign address ack");
      chk(code[0], 8'hc0, "foreign write ignored");
      enable_mode = 2'h0;
      repeat (4) @(negedge clk);
      chk(shutdown, 1'b1, "shutdown");
      chk(code[3], 8'h00, "code in off mode");
      enable_mode = 2'h1;
      repeat (4) @(negedge clk);
      chk(night_range, 1'b1, "night range");
      chk(code[3], 8'h01, "code in night mode");
      enable_mode = 2'h3;
      repeat (4) @(negedge clk);
      enable_mode = 2'h2;
      i_rcp_i2c_host.rd(7'h74, 8'h0a, 5, q, ok);
      for (int i = 0; i < 5; i++) chk(q[i], 8'h00, "restored");
   endtask : t_codes
   task automatic wait_slot(output int waited);
      logic [2:0] prev;
      prev = active_slot;
      waited = 0;
      while (active_slot === prev && waited < 40000) begin
         @(negedge clk);
         waited++;
      end
      chk(waited < 40000, 1'b1, "slot advance");
   endtask : wait_slot
   task automatic t_mode(input logic [1:0] m, input logic [2:0] dur, input logic [2:0] f2,
                         input logic [2:0] f1, input logic [7:0] fsel, input logic [7:0] g1);
      int n;
      int w;
      int s;
      n = (m == 2'h1) ? 4 : (m == 2'h2) ? 6 : 8;
      first_fade_constant = f1;
      i_rcp_i2c_host.wr(7'h74, 8'h0f, '{{m, dur, f2}, fsel, g1}, ok);
      w = 0;
      while (active_slot !== 3'h0 || w == 0) wait_slot(w);
      for (int k = 1; k <= n; k++) begin
         s = k % n;
         wait_slot(w);
         chk(active_slot, s, "slot order");
         chk(w, SLOT_MS[dur] * MS, "slot length");
         chk(group1_on, g1[s], "group1 state");
         chk(active_fade_ms, fsel[s] ? FADE_MS[f2] : FADE_MS[f1], "fade");
      end
   endtask : t_mode
   task automatic t_engine_off();
      first_fade_constant = 3'h7;
      i_rcp_i2c_host.wr(7'h74, 8'h0f, '{8'h3f, 8'hff, 8'hff}, ok);
      repeat (4) @(negedge clk);
      chk(engine_on, 1'b0, "engine off");
      chk(group1_on, 1'b0, "group1 off");
      chk(active_fade_ms, 12'd4000, "first fade in off");
   endtask : t_engine_off
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_defaults();
      t_codes();
      t_mode(2'h1, 3'h3, 3'h5, 3'h2, 8'h05, 8'h06);
      t_mode(2'h2, 3'h0, 3'h7, 3'h0, 8'h2a, 8'h31);
      t_mode(2'h3, 3'h1, 3'h1, 3'h6, 8'hc3, 8'h9c);
      t_engine_off();
      results();
   end
endmodule : rcp_top_tb
